//--- cbio_pkg.sv
/*
 * Constants for the bridge I/O window bound and interrupt header registers.
 * Assumes an AXI4-Lite register bus with 32-bit data and 12-bit addresses.
 */
package cbio_pkg;
   // ----------------------------------------------------------------
   // Address layout
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int FUNC_LSB = 10;       // Function select in address bits 11:10
   localparam int IDX_LSB = 2;         // Register index in address bits 9:2
   localparam logic [1:0] FUNC_CNT = 2'h3;
   localparam logic [7:0] IDX_LO0 = 8'h2C;
   localparam logic [7:0] IDX_HI0 = 8'h30;
   localparam logic [7:0] IDX_LO1 = 8'h34;
   localparam logic [7:0] IDX_HI1 = 8'h38;
   localparam logic [7:0] IDX_LINE = 8'h3C;
   localparam logic [7:0] IDX_PIN = 8'h3D;
   localparam logic [7:0] IDX_TIE = 8'h40;
   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] BOUND_MASK = 32'h0000_FFFC;
   localparam logic [31:0] BOUND_LOW_ONES = 32'h0000_0003;
   localparam logic [31:0] BOUND_RST = 32'h0000_0000;
   localparam logic [7:0] LINE_RST = 8'hFF;
   localparam logic [1:0] TIE_RST = 2'h0;
   localparam int TIE_PAIR_BIT = 0;
   localparam int TIE_ALL_BIT = 1;
   localparam logic [7:0] PIN_A = 8'h01;
   localparam logic [7:0] PIN_C = 8'h03;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------------------------------
   // Register select
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CBIO_SEL_NONE = 3'h0,
      CBIO_SEL_LO0 = 3'h1,
      CBIO_SEL_HI0 = 3'h2,
      CBIO_SEL_LO1 = 3'h3,
      CBIO_SEL_HI1 = 3'h4,
      CBIO_SEL_LINE = 3'h5,
      CBIO_SEL_PIN = 3'h6,
      CBIO_SEL_TIE = 3'h7
   } cbio_sel_t;
endpackage

//--- cbio_regs.sv
/*
 * I/O window bound registers, per-function interrupt line scratch, interrupt
 * pin report and window address compare, behind an AXI4-Lite slave.
 * Assumes the address inputs are on the same clock; one read and one write
 * at most are under way at a time.
 */
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Two 32-bit upper-bound registers, reset zero
// - Upper bound steers forwarding in both directions
// - Upper-bound bits 15..2 are read/write
// - Upper-bound bits 31..16 read zero
// - Upper-bound bits 1..0 read zero, writes ignored
// - Compare treats upper-bound low bits as ones
// - Window active only if either bound nonzero
// - Interrupt line byte, reset all ones, unused
// - Each function owns its interrupt line byte
// - Pin report depends on function and ties
// - No ties: functions read 1, 2, 3
// - Pair tie: functions 0,1 read 1
// - All tie: every function reads 1
// - Lower-bound bits 31..16 and 1..0 zero
module cbio_regs
   import cbio_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [ADDR_W-1:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic [31:0] pci_io_addr_in,
   input wire logic [31:0] card_io_addr_in,
   output logic [1:0] win_enable_out,
   output logic [1:0] to_card_hit_out,
   output logic [1:0] to_pci_hit_out
);
   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // Word index decode, shared by read and write paths
   function automatic cbio_sel_t sel_of(input logic [ADDR_W-1:0] a);
      logic [7:0] idx;
      idx = a[IDX_LSB +: 8];
      if (a[FUNC_LSB +: 2] == FUNC_CNT) begin
         sel_of = CBIO_SEL_NONE;
      end else if (idx == IDX_LO0) begin
         sel_of = CBIO_SEL_LO0;
      end else if (idx == IDX_HI0) begin
         sel_of = CBIO_SEL_HI0;
      end else if (idx == IDX_LO1) begin
         sel_of = CBIO_SEL_LO1;
      end else if (idx == IDX_HI1) begin
         sel_of = CBIO_SEL_HI1;
      end else if (idx == IDX_LINE) begin
         sel_of = CBIO_SEL_LINE;
      end else if (idx == IDX_PIN) begin
         sel_of = CBIO_SEL_PIN;
      end else if (idx == IDX_TIE) begin
         sel_of = CBIO_SEL_TIE;
      end else begin
         sel_of = CBIO_SEL_NONE;
      end
   endfunction

   // Pin code reported by a function under the tie settings
   function automatic logic [7:0] pin_of(input logic [1:0] fn, input logic [1:0] tie);
      if (tie[TIE_ALL_BIT]) begin
         pin_of = PIN_A;
      end else if (tie[TIE_PAIR_BIT] && fn != 2'h2) begin
         pin_of = PIN_A;
      end else begin
         pin_of = PIN_A + {6'h00, fn};
      end
   endfunction

   // Byte-lane merge of write data into an old value
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            merge[8*i +: 8] = d[8*i +: 8];
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [31:0] lo_r [2];
   logic [31:0] hi_r [2];
   logic [7:0] line_r [3];
   logic [1:0] tie_r;
   logic aw_got_r, w_got_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic [1:0] en_r, card_hit_r, pci_hit_r;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // Handshakes and the selected registers
   wire aw_hs = s_axi_awvalid_in && awready_r;
   wire w_hs = s_axi_wvalid_in && wready_r;
   wire ar_hs = s_axi_arvalid_in && arready_r;
   wire b_hs = bvalid_r && s_axi_bready_in;
   wire r_hs = rvalid_r && s_axi_rready_in;
   wire wr_go = aw_got_r && w_got_r && !bvalid_r;
   wire cbio_sel_t wr_sel = sel_of(aw_addr_r);
   wire [1:0] wr_fn = aw_addr_r[FUNC_LSB +: 2];
   wire cbio_sel_t rd_sel = sel_of(s_axi_araddr_in);
   wire [1:0] rd_fn = s_axi_araddr_in[FUNC_LSB +: 2];

   // Read data selection
   logic [31:0] rd_data;
   always_comb begin
      unique case (rd_sel)
         CBIO_SEL_LO0: rd_data = lo_r[0];
         CBIO_SEL_HI0: rd_data = hi_r[0];
         CBIO_SEL_LO1: rd_data = lo_r[1];
         CBIO_SEL_HI1: rd_data = hi_r[1];
         CBIO_SEL_LINE: rd_data = {24'h00_0000, line_r[rd_fn]};
         CBIO_SEL_PIN: rd_data = {24'h00_0000, pin_of(rd_fn, tie_r)};
         CBIO_SEL_TIE: rd_data = {30'h0000_0000, tie_r};
         CBIO_SEL_NONE: rd_data = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   // Address and data are held until both are in, then answered
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         aw_addr_r <= '0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else begin
         if (aw_hs) begin
            aw_got_r <= 1'b1;
            awready_r <= 1'b0;
            aw_addr_r <= s_axi_awaddr_in;
         end
         if (w_hs) begin
            w_got_r <= 1'b1;
            wready_r <= 1'b0;
            w_data_r <= s_axi_wdata_in;
            w_strb_r <= s_axi_wstrb_in;
         end
         if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= (wr_sel == CBIO_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         end
         if (b_hs) begin
            bvalid_r <= 1'b0;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   // Window bound registers; only bits 15..2 take writes
   for (genvar k = 0; k < 2; k++) begin : g_win
      wire cbio_sel_t lo_sel = k ? CBIO_SEL_LO1 : CBIO_SEL_LO0;
      wire cbio_sel_t hi_sel = k ? CBIO_SEL_HI1 : CBIO_SEL_HI0;
      wire [31:0] lo_nxt = merge(lo_r[k], w_data_r, w_strb_r) & BOUND_MASK;
      wire [31:0] hi_nxt = merge(hi_r[k], w_data_r, w_strb_r) & BOUND_MASK;
      always_ff @(posedge ref_clk_in) begin
         if (!reset_n_in) begin
            lo_r[k] <= BOUND_RST;
            hi_r[k] <= BOUND_RST;
         end else if (wr_go && wr_sel == lo_sel) begin
            lo_r[k] <= lo_nxt;
         end else if (wr_go && wr_sel == hi_sel) begin
            hi_r[k] <= hi_nxt;
         end
      end
   end

   // One interrupt line byte per function; only the bus read path uses it
   for (genvar f = 0; f < 3; f++) begin : g_line
      always_ff @(posedge ref_clk_in) begin
         if (!reset_n_in) begin
            line_r[f] <= LINE_RST;
         end else if (wr_go && wr_sel == CBIO_SEL_LINE && wr_fn == f && w_strb_r[0]) begin
            line_r[f] <= w_data_r[7:0];
         end
      end
   end

   // Tie settings
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         tie_r <= TIE_RST;
      end else if (wr_go && wr_sel == CBIO_SEL_TIE && w_strb_r[0]) begin
         tie_r <= w_data_r[1:0];
      end
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   // Data answer one cycle after the address is taken
   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OKAY;
      end else if (ar_hs) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= rd_data;
         rresp_r <= (rd_sel == CBIO_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (r_hs) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Window compare
   // ----------------------------------------------------------------
   // Enable, top with forced low ones, and inclusive range tests
   logic [1:0] en_nxt, card_nxt, pci_nxt;
   always_comb begin
      for (int k = 0; k < 2; k++) begin
         en_nxt[k] = (lo_r[k] != 32'h0000_0000) || (hi_r[k] != 32'h0000_0000);
         card_nxt[k] = en_nxt[k] && pci_io_addr_in >= lo_r[k]
                       && pci_io_addr_in <= (hi_r[k] | BOUND_LOW_ONES);
         pci_nxt[k] = !(en_nxt[k] && card_io_addr_in >= lo_r[k]
                       && card_io_addr_in <= (hi_r[k] | BOUND_LOW_ONES));
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         en_r <= 2'h0;
         card_hit_r <= 2'h0;
         pci_hit_r <= 2'h0;
      end else begin
         en_r <= en_nxt;
         card_hit_r <= card_nxt;
         pci_hit_r <= pci_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign s_axi_awready_out = awready_r;
   assign s_axi_wready_out = wready_r;
   assign s_axi_bvalid_out = bvalid_r;
   assign s_axi_bresp_out = bresp_r;
   assign s_axi_arready_out = arready_r;
   assign s_axi_rvalid_out = rvalid_r;
   assign s_axi_rdata_out = rdata_r;
   assign s_axi_rresp_out = rresp_r;
   assign win_enable_out = en_r;
   assign to_card_hit_out = card_hit_r;
   assign to_pci_hit_out = pci_hit_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);

   a_hi_reset_zero: assert property (
      $rose(reset_n_in) |-> hi_r[0] == 32'h0 && hi_r[1] == 32'h0)
      else $error("upper bound not zero after reset");
   a_hi_ro_bits: assert property (
      (hi_r[0] & ~BOUND_MASK) == 32'h0 && (hi_r[1] & ~BOUND_MASK) == 32'h0)
      else $error("upper bound read-only bits set");
   a_hi_write_take: assert property (
      wr_go && wr_sel == CBIO_SEL_HI0 && w_strb_r == 4'hF
      |=> hi_r[0] == ($past(w_data_r) & BOUND_MASK))
      else $error("upper bound write lost");
   a_lo_ro_bits: assert property (
      (lo_r[0] & ~BOUND_MASK) == 32'h0 && (lo_r[1] & ~BOUND_MASK) == 32'h0)
      else $error("lower bound read-only bits set");
   a_win_enable: assert property (
      ##1 win_enable_out[1] == $past(lo_r[1] != 32'h0 || hi_r[1] != 32'h0))
      else $error("window enable wrong");
   a_hit_top: assert property (
      to_card_hit_out[0]
      |-> $past(pci_io_addr_in <= {hi_r[0][31:2], 2'b11} && pci_io_addr_in >= lo_r[0]))
      else $error("claim outside window");
   // Enable and hit flops load together, so both are compared at one edge
   a_pci_fwd: assert property (
      $past(reset_n_in) && !en_r[0] && !en_r[1] |-> to_pci_hit_out == 2'h3)
      else $error("card cycle not sent to host side");
   a_line_reset: assert property ($rose(reset_n_in) |-> line_r[1] == LINE_RST)
      else $error("interrupt line not all ones after reset");
   a_line_separate: assert property (wr_go && wr_fn == 2'h0 |=> $stable(line_r[1]))
      else $error("interrupt line shared between functions");
   a_pin_all: assert property (
      ar_hs && rd_sel == CBIO_SEL_PIN && tie_r[TIE_ALL_BIT]
      |=> rdata_r == {24'h0, PIN_A})
      else $error("pin code wrong under all tie");
   a_pin_pair: assert property (
      ar_hs && rd_sel == CBIO_SEL_PIN && tie_r == 2'h1 && rd_fn == 2'h2
      |=> rdata_r == {24'h0, PIN_C})
      else $error("pin code wrong under pair tie");
   a_pin_none: assert property (
      ar_hs && rd_sel == CBIO_SEL_PIN && tie_r == 2'h0
      |=> rdata_r[7:0] == $past(rd_fn) + 8'h01)
      else $error("pin code wrong without ties");
   c_hi_write: cover property (wr_go && wr_sel == CBIO_SEL_HI1);
   c_card_hit: cover property (to_card_hit_out[0] ##1 to_card_hit_out[1]);
   c_pin_read: cover property (ar_hs && rd_sel == CBIO_SEL_PIN ##1 r_hs);
endmodule
`default_nettype wire

//--- tb.sv
/*
 * Self-checking bench for the I/O window bound and interrupt header block.
 * Assumes the block answers on AXI4-Lite and registers its compare outputs.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import cbio_pkg::*;
   // ----------------------------------------------------------------
   // Signals and design instance
   // ----------------------------------------------------------------
   logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, pci_a, card_a, rd;
   logic [3:0] wstrb;
   logic [1:0] rs, en, tc, tp;
   wire logic awready, wready, bvalid, arready, rvalid;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   int err_count, check_count;
   cbio_regs cbio_regs_i (.ref_clk_in(clk), .reset_n_in(rst_n),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
      .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .pci_io_addr_in(pci_a),
      .card_io_addr_in(card_a), .win_enable_out(en), .to_card_hit_out(tc),
      .to_pci_hit_out(tp));
   // Clock at 25 ns period
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ----------------------------------------------------------------
   // Bus and compare tasks
   // ----------------------------------------------------------------
   function automatic logic [11:0] ad(input logic [1:0] f, input logic [7:0] i);
      return {f, i, 2'b00};
   endfunction
   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic timeout();
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
      tally_and_finish();
   endtask
   // Write with both channels offered together; waits for the response
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      bit ad_ok, wd_ok;
      int n;
      ad_ok = 0;
      wd_ok = 0;
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50 && !(ad_ok && wd_ok); n++) begin
         @(posedge clk);
         if (!ad_ok && awready) begin
            awvalid <= 1'b0;
            ad_ok = 1;
         end
         if (!wd_ok && wready) begin
            wvalid <= 1'b0;
            wd_ok = 1;
         end
      end
      for (n = 0; n < 50 && !(ad_ok && wd_ok && bvalid); n++) @(posedge clk);
      if (!bvalid) timeout();
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
   endtask
   // Read and compare data and response
   task automatic rdc(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50 && !(arvalid && arready); n++) @(posedge clk);
      arvalid <= 1'b0;
      for (n = 0; n < 50 && !rvalid; n++) @(posedge clk);
      if (!rvalid) timeout();
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
      chk(rd, ed);
      chk({30'h0, rs}, {30'h0, er});
   endtask
   // Present addresses and check enable, to-card hit and to-host hit
   task automatic probe(input logic [31:0] p, input logic [31:0] c, input logic [5:0] e);
      @(posedge clk);
      pci_a <= p;
      card_a <= c;
      repeat (2) @(posedge clk);
      chk({26'h0, en, tc, tp}, {26'h0, e});
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      int f, t;
      rst_n = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = '0;
      pci_a = '0;
      card_a = '0;
      err_count = 0;
      check_count = 0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values and untied pin codes
      rdc(ad(0, IDX_HI0), 32'h0, RESP_OKAY);
      rdc(ad(0, IDX_HI1), 32'h0, RESP_OKAY);
      for (f = 0; f < 3; f++) begin
         rdc(ad(f[1:0], IDX_LINE), 32'h0000_00FF, RESP_OKAY);
         rdc(ad(f[1:0], IDX_PIN), f + 1, RESP_OKAY);
      end
      probe(32'h0, 32'h0, 6'h03);
      $display("test reset done");
      // Upper- and lower-bound field masking and lane merge
      wr(ad(0, IDX_HI0), 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
      rdc(ad(0, IDX_HI0), 32'h0000_FFFC, RESP_OKAY);
      wr(ad(0, IDX_HI0), 32'hAAAA_12AA, 4'h2, RESP_OKAY);
      rdc(ad(0, IDX_HI0), 32'h0000_12FC, RESP_OKAY);
      wr(ad(0, IDX_LO0), 32'hFFFF_0103, 4'hF, RESP_OKAY);
      rdc(ad(0, IDX_LO0), 32'h0000_0100, RESP_OKAY);
      wr(ad(0, IDX_HI0), 32'h0000_01FC, 4'hF, RESP_OKAY);
      $display("test bounds done");
      // Window compare at and around the bounds
      probe(32'h0000_01FF, 32'h0000_0200, 6'h17);
      probe(32'h0000_0100, 32'h0000_01FE, 6'h16);
      probe(32'h0000_00FF, 32'h0001_0100, 6'h13);
      wr(ad(0, IDX_HI1), 32'h0000_0004, 4'hF, RESP_OKAY);
      probe(32'h0000_0007, 32'h0000_0008, 6'h3B);
      probe(32'h0000_0004, 32'h0000_0007, 6'h39);
      wr(ad(0, IDX_HI1), 32'h0, 4'hF, RESP_OKAY);
      probe(32'h0000_0000, 32'h0000_0000, 6'h13);
      $display("test compare done");
      // Per-function scratch bytes
      wr(ad(1, IDX_LINE), 32'h0000_005A, 4'h1, RESP_OKAY);
      rdc(ad(0, IDX_LINE), 32'h0000_00FF, RESP_OKAY);
      rdc(ad(1, IDX_LINE), 32'h0000_005A, RESP_OKAY);
      rdc(ad(2, IDX_LINE), 32'h0000_00FF, RESP_OKAY);
      $display("test scratch done");
      // Pin code for every tie setting
      for (t = 3; t >= 0; t--) begin
         wr(ad(0, IDX_TIE), t, 4'h1, RESP_OKAY);
         for (f = 0; f < 3; f++) begin
            rdc(ad(f[1:0], IDX_PIN), (t[1] || (t[0] && f == 1)) ? 1 : f + 1,
                RESP_OKAY);
         end
      end
      wr(ad(1, IDX_PIN), 32'h0000_0077, 4'h1, RESP_OKAY);
      rdc(ad(1, IDX_PIN), 32'h0000_0002, RESP_OKAY);
      $display("test pin done");
      // Unmapped places
      rdc(ad(3, IDX_HI0), 32'h0, RESP_SLVERR);
      wr(ad(0, 8'h50), 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
      rdc(ad(0, IDX_HI0), 32'h0000_01FC, RESP_OKAY);
      $display("test unmapped done");
      // Reset in mid-run returns the registers to their reset values
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rdc(ad(0, IDX_HI0), 32'h0, RESP_OKAY);
      rdc(ad(0, IDX_LO0), 32'h0, RESP_OKAY);
      rdc(ad(1, IDX_LINE), 32'h0000_00FF, RESP_OKAY);
      probe(32'h0000_0100, 32'h0000_0100, 6'h03);
      $display("test mid reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
